// file: logic/cws_cfg.svh
// constants for the configuration word clock source block
`ifndef CWS_CFG_SVH
`define CWS_CFG_SVH
// stored word indices, byte address is four times the index
`define CWS_WORD_ONE_IDX 16'h2007
`define CWS_WORD_TWO_IDX 16'h2008
// local registers, byte addresses
`define CWS_OSC_CONTROL_ADDR 16'h0000
`define CWS_OSC_TUNING_ADDR 16'h0004
`define CWS_STATUS_ADDR 16'h0008
// erased values of the stored words
`define CWS_WORD_ONE_ERASED 16'h3FFF
`define CWS_WORD_TWO_ERASED 16'h3FFF
// word one fields
`define CWS_FOSC_LSB 0
`define CWS_WATCHDOG_ENABLE_BIT_BIT 3
`define CWS_POWER_UP_TIMER_ENABLE_BIT 4
`define CWS_MASTER_CLEAR_PIN_ENABLE_BIT 5
`define CWS_CP_BIT 6
`define CWS_BROWN_OUT_RESET_ENABLE_LSB 8
// oscillator selection codes
`define CWS_FOSC_RC_CLK 3'h7
`define CWS_FOSC_RC_IO 3'h6
`define CWS_FOSC_INT_CLK 3'h5
`define CWS_FOSC_INT_IO 3'h4
`define CWS_FOSC_EXT 3'h3
`define CWS_FOSC_HS 3'h2
`define CWS_FOSC_XT 3'h1
`define CWS_FOSC_LP 3'h0
// oscillator control fields and reset
`define CWS_INTERNAL_FREQUENCY_SELECT_LSB 4
`define CWS_INTERNAL_LOCK_FLAG_BIT 3
`define CWS_INTERNAL_STABLE_FLAG_BIT 2
`define CWS_INTERNAL_FREQUENCY_SELECT_RESET 2'h2
`define CWS_TUNE_RESET 6'h00
// start-up timer oscillations
`define CWS_OST_COUNT 11'h400
`endif

// file: logic/cws_pkg.sv
// types shared by the configuration word clock source block
package cws_pkg;
  // one mode encoding for clock tree and pin mux
  typedef enum logic [2:0] {
    CWS_LOW_POWER_CRYSTAL_MODE,
    CWS_MEDIUM_GAIN_CRYSTAL_MODE,
    CWS_HIGH_SPEED_CRYSTAL_MODE,
    CWS_EXTERNAL_CLOCK_INPUT_MODE,
    CWS_INTERNAL_OSCILLATOR_PINS_IO,
    CWS_INTERNAL_OSCILLATOR_WITH_CLOCK_OUT,
    CWS_RESISTOR_CAPACITOR_PIN_IO,
    CWS_RESISTOR_CAPACITOR_WITH_CLOCK_OUT
  } cws_mode_t;
  // pin roles of the two oscillator pins
  typedef struct packed {
    logic primary_gpio;      // primary pin free as general io
    logic primary_clock_in;  // primary pin takes clock or rc network
    logic secondary_gpio;    // secondary pin free as general io
    logic secondary_clk_out; // secondary pin drives divided clock
    logic resonator;         // both pins hold a crystal
  } cws_pins_t;
endpackage

// file: logic/cws_mode_decode.sv
// oscillator selection field decoder
`timescale 1ns/1ps
`default_nettype none
`include "cws_cfg.svh"
module cws_mode_decode
  import cws_pkg::*;
(
  input wire logic [2:0] i_fosc, // selection field
  output cws_mode_t o_mode,      // decoded mode
  output cws_pins_t o_pins       // decoded pin roles
);
  // field to mode
  always_comb begin
    case (i_fosc)
      `CWS_FOSC_RC_CLK: o_mode = CWS_RESISTOR_CAPACITOR_WITH_CLOCK_OUT;
      `CWS_FOSC_RC_IO: o_mode = CWS_RESISTOR_CAPACITOR_PIN_IO;
      `CWS_FOSC_INT_CLK: o_mode = CWS_INTERNAL_OSCILLATOR_WITH_CLOCK_OUT;
      `CWS_FOSC_INT_IO: o_mode = CWS_INTERNAL_OSCILLATOR_PINS_IO;
      `CWS_FOSC_EXT: o_mode = CWS_EXTERNAL_CLOCK_INPUT_MODE;
      `CWS_FOSC_HS: o_mode = CWS_HIGH_SPEED_CRYSTAL_MODE;
      `CWS_FOSC_XT: o_mode = CWS_MEDIUM_GAIN_CRYSTAL_MODE;
      default: o_mode = CWS_LOW_POWER_CRYSTAL_MODE;
    endcase
  end
  // mode to pin roles
  always_comb begin
    o_pins = '0;
    case (o_mode)
      CWS_RESISTOR_CAPACITOR_WITH_CLOCK_OUT: begin
        o_pins.primary_clock_in = 1'b1;
        o_pins.secondary_clk_out = 1'b1;
      end
      CWS_RESISTOR_CAPACITOR_PIN_IO: begin
        o_pins.primary_clock_in = 1'b1;
        o_pins.secondary_gpio = 1'b1;
      end
      CWS_INTERNAL_OSCILLATOR_WITH_CLOCK_OUT: begin
        o_pins.primary_gpio = 1'b1;
        o_pins.secondary_clk_out = 1'b1;
      end
      CWS_INTERNAL_OSCILLATOR_PINS_IO: begin
        o_pins.primary_gpio = 1'b1;
        o_pins.secondary_gpio = 1'b1;
      end
      CWS_EXTERNAL_CLOCK_INPUT_MODE: begin
        o_pins.primary_clock_in = 1'b1;
        o_pins.secondary_gpio = 1'b1;
      end
      default: o_pins.resonator = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// file: logic/cws_startup_timer.sv
// oscillator start-up timer, counts rising edges on the primary pin
`timescale 1ns/1ps
`default_nettype none
`include "cws_cfg.svh"
module cws_startup_timer (
  input wire logic i_clk,     // system clock
  input wire logic i_reset_n, // sync reset, active low
  input wire logic i_start,   // start pulse
  input wire logic i_enable,  // crystal mode selected
  input wire logic i_osc,     // primary pin level
  output logic o_busy         // counting, hold reset
);
  logic [10:0] count_q;
  logic osc_prev_q;
  // previous pin level for edge detect
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= i_osc;
    end
  end
  // count oscillations while busy
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
      count_q <= '0;
    end else if (i_start) begin
      o_busy <= i_enable;
      count_q <= '0;
    end else if (o_busy && i_osc && !osc_prev_q) begin
      count_q <= count_q + 11'h001;
      if (count_q == `CWS_OST_COUNT - 11'h001) begin
        o_busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/cws_config_core.sv
// configuration word store, clock source select and apb registers
// How it works
// - rc clock-out mode drives secondary at quarter rate
// - rc io mode frees secondary pin
// - codes 111 and 110 select rc modes
// - codes 101 and 100 select internal oscillator
// - code 011 selects external clock input
// - codes 010 001 000 select crystal gains
// - words sit at 2007h and 2008h
// - words reachable only in programming mode
// - disabling code protect erases program memory
// - brown-out enable leaves power-up timer alone
// - master clear stops internal or rc oscillator
// - crystal modes hold reset for 1024 oscillations
// - external clock mode has no start-up delay
`timescale 1ns/1ps
`default_nettype none
`include "cws_cfg.svh"
module cws_config_core
  import cws_pkg::*;
(
  input wire logic i_clk,              // 100 MHz clock
  input wire logic i_reset_n,          // sync reset, active low
  input wire logic i_nv_init_n,        // blank-part init of stored words
  input wire logic i_psel,             // apb select
  input wire logic i_penable,          // apb enable
  input wire logic i_pwrite,           // apb direction
  input wire logic [15:0] i_paddr,     // apb byte address
  input wire logic [31:0] i_pwdata,    // apb write data
  output logic [31:0] o_prdata,        // apb read data
  output logic o_pready,               // apb ready
  output logic o_pslverr,              // apb error
  input wire logic i_program_mode,     // programming tool has entered
  input wire logic i_master_clear_n,   // master clear input, active low
  input wire logic i_wake,             // wake from sleep pulse
  input wire logic i_primary_osc_in,   // primary pin level
  input wire logic i_rc_osc,           // rc oscillator level
  input wire logic i_int_osc,          // internal oscillator level
  input wire logic i_int_lock,         // internal lock flag source
  input wire logic i_int_stable,       // internal stable flag source
  output cws_mode_t o_clock_source,    // system clock source
  output cws_pins_t o_pins,            // pin roles
  output logic o_secondary_pin_out,    // clock output value
  output logic o_secondary_pin_oe,     // clock output drive enable
  output logic o_internal_osc_run,     // internal oscillator enable
  output logic o_rc_osc_run,           // rc oscillator enable
  output logic o_hold_reset,           // hold core in reset
  output logic o_power_up_timer_en,    // power-up timer enable
  output logic [1:0] o_brown_out_en,   // brown-out enable field
  output logic o_watchdog_en,          // watchdog enable
  output logic o_master_clear_pin_en,  // pin acts as master clear
  output logic o_erase_strobe,         // erase all program memory
  output logic [1:0] o_freq_select,    // internal frequency select
  output logic [5:0] o_freq_trim       // frequency trim field
);
  // byte address of a stored word from its index
  function automatic logic [15:0] word_addr(input logic [15:0] idx);
    word_addr = {idx[13:0], 2'b00};
  endfunction

  logic [15:0] word_one_q;
  logic [15:0] word_two_q;
  logic [15:0] active_one_q;
  logic loaded_q;
  logic [1:0] internal_frequency_select_q;
  logic [5:0] tune_q;
  logic access;
  logic wr_en;
  logic hit_one;
  logic hit_two;
  logic hit_words;
  logic mapped;
  logic [31:0] rd_d;
  logic err_d;
  cws_mode_t mode;
  cws_pins_t pins;
  logic ost_busy;
  logic ost_start;
  logic crystal;
  logic master_clear_input_asserted;
  logic stop_osc;
  logic div_src;
  logic src_prev_q;
  logic [1:0] div_q;
  logic started_q;

  // apb decode, one wait state
  assign access = i_psel && i_penable;
  assign wr_en = access && o_pready && i_pwrite && !o_pslverr;
  assign hit_one = (i_paddr == word_addr(`CWS_WORD_ONE_IDX));
  assign hit_two = (i_paddr == word_addr(`CWS_WORD_TWO_IDX));
  assign hit_words = hit_one || hit_two;
  assign mapped = hit_words || (i_paddr == `CWS_OSC_CONTROL_ADDR) ||
    (i_paddr == `CWS_OSC_TUNING_ADDR) || (i_paddr == `CWS_STATUS_ADDR);

  // read mux and error
  always_comb begin
    rd_d = '0;
    err_d = !mapped;
    if (hit_words && !i_program_mode) begin
      err_d = 1'b1;
    end else if (hit_one) begin
      rd_d[15:0] = word_one_q;
    end else if (hit_two) begin
      rd_d[15:0] = word_two_q;
    end else if (i_paddr == `CWS_OSC_CONTROL_ADDR) begin
      rd_d[`CWS_INTERNAL_FREQUENCY_SELECT_LSB +: 2] = internal_frequency_select_q;
      rd_d[`CWS_INTERNAL_LOCK_FLAG_BIT] = i_int_lock;
      rd_d[`CWS_INTERNAL_STABLE_FLAG_BIT] = i_int_stable;
    end else if (i_paddr == `CWS_OSC_TUNING_ADDR) begin
      rd_d[5:0] = tune_q;
    end else if (i_paddr == `CWS_STATUS_ADDR) begin
      rd_d[2:0] = o_clock_source;
      rd_d[3] = o_hold_reset;
      rd_d[4] = loaded_q;
      rd_d[5] = i_program_mode;
    end
  end

  // apb answer registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (access && !o_pready) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_d;
      o_pslverr <= err_d;
    end else begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end
  end

  // stored words, kept across core reset
  always_ff @(posedge i_clk) begin
    if (!i_nv_init_n) begin
      word_one_q <= `CWS_WORD_ONE_ERASED;
      word_two_q <= `CWS_WORD_TWO_ERASED;
    end else if (wr_en) begin
      if (hit_one) begin
        word_one_q <= i_pwdata[15:0];
      end
      if (hit_two) begin
        word_two_q <= i_pwdata[15:0];
      end
    end
  end

  // erase when protection turns off
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_erase_strobe <= 1'b0;
    end else begin
      o_erase_strobe <= wr_en && hit_one && !word_one_q[`CWS_CP_BIT] &&
        i_pwdata[`CWS_CP_BIT];
    end
  end

  // oscillator control and tuning
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      internal_frequency_select_q <= `CWS_INTERNAL_FREQUENCY_SELECT_RESET;
      tune_q <= `CWS_TUNE_RESET;
    end else if (wr_en) begin
      if (i_paddr == `CWS_OSC_CONTROL_ADDR) begin
        internal_frequency_select_q <= i_pwdata[`CWS_INTERNAL_FREQUENCY_SELECT_LSB +: 2];
      end
      if (i_paddr == `CWS_OSC_TUNING_ADDR) begin
        tune_q <= i_pwdata[5:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      loaded_q <= 1'b0;
      active_one_q <= `CWS_WORD_ONE_ERASED;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      active_one_q <= word_one_q;
    end
  end

  // single decode of the held field
  cws_mode_decode u_decode (
    .i_fosc(active_one_q[`CWS_FOSC_LSB +: 3]),
    .o_mode(mode),
    .o_pins(pins)
  );

  // crystal modes start the timer
  assign crystal = pins.resonator;

  // timer kick has been given since reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      started_q <= 1'b0;
    end else if (loaded_q) begin
      started_q <= 1'b1;
    end
  end

  // kick after load and after wake
  assign ost_start = loaded_q && (!started_q || i_wake);

  // oscillation counter for crystal modes
  cws_startup_timer u_ost (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(ost_start),
    .i_enable(crystal),
    .i_osc(i_primary_osc_in),
    .o_busy(ost_busy)
  );

  // core reset hold, decided at the kick
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_hold_reset <= 1'b1;
    end else if (!loaded_q) begin
      o_hold_reset <= 1'b1;
    end else if (ost_start) begin
      o_hold_reset <= crystal;
    end else begin
      o_hold_reset <= ost_busy;
    end
  end

  // mode class helpers, shared by divider and enables
  function automatic logic is_rc(input cws_mode_t md);
    is_rc = (md == CWS_RESISTOR_CAPACITOR_WITH_CLOCK_OUT) ||
      (md == CWS_RESISTOR_CAPACITOR_PIN_IO);
  endfunction

  // internal oscillator modes
  function automatic logic is_internal(input cws_mode_t md);
    is_internal = (md == CWS_INTERNAL_OSCILLATOR_WITH_CLOCK_OUT) ||
      (md == CWS_INTERNAL_OSCILLATOR_PINS_IO);
  endfunction

  // held mode to the clock tree
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_clock_source <= CWS_LOW_POWER_CRYSTAL_MODE;
    end else if (loaded_q) begin
      o_clock_source <= mode;
    end
  end

  // same mode drives the pin mux
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pins <= '{resonator: 1'b1, default: 1'b0};
    end else if (loaded_q) begin
      o_pins <= pins;
    end
  end

  // secondary pin drives in clock-out modes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_secondary_pin_oe <= 1'b0;
    end else if (loaded_q) begin
      o_secondary_pin_oe <= pins.secondary_clk_out;
    end
  end

  // source for the quarter-rate output
  assign div_src = is_rc(mode) ? i_rc_osc : i_int_osc;

  // source edge detect, stopped sources idle low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= div_src;
    end
  end

  // two-bit divider, top bit is rate over four
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_q <= 2'h0;
    end else if (!o_secondary_pin_oe) begin
      div_q <= 2'h0;
    end else if (div_src && !src_prev_q) begin
      div_q <= div_q + 2'h1;
    end
  end

  // divided clock onto the secondary pin
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_secondary_pin_out <= 1'b0;
    end else begin
      o_secondary_pin_out <= o_secondary_pin_oe && div_q[1];
    end
  end

  // master clear counts only when the pin has that role
  assign master_clear_input_asserted = o_master_clear_pin_en && !i_master_clear_n;
  assign stop_osc = master_clear_input_asserted;

  // internal oscillator stops under master clear
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_internal_osc_run <= 1'b0;
    end else if (loaded_q) begin
      o_internal_osc_run <= is_internal(mode) && !stop_osc;
    end
  end

  // rc oscillator stops under master clear
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rc_osc_run <= 1'b0;
    end else if (loaded_q) begin
      o_rc_osc_run <= is_rc(mode) && !stop_osc;
    end
  end

  // each enable follows only its own field
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_power_up_timer_en <= 1'b0;
      o_brown_out_en <= 2'h0;
      o_watchdog_en <= 1'b0;
      o_master_clear_pin_en <= 1'b0;
    end else if (loaded_q) begin
      // power-up timer enable bit is active low
      o_power_up_timer_en <= !active_one_q[`CWS_POWER_UP_TIMER_ENABLE_BIT];
      o_brown_out_en <= active_one_q[`CWS_BROWN_OUT_RESET_ENABLE_LSB +: 2];
      o_watchdog_en <= active_one_q[`CWS_WATCHDOG_ENABLE_BIT_BIT];
      o_master_clear_pin_en <= active_one_q[`CWS_MASTER_CLEAR_PIN_ENABLE_BIT];
    end
  end

  // internal oscillator frequency and trim outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_freq_select <= `CWS_INTERNAL_FREQUENCY_SELECT_RESET;
      o_freq_trim <= `CWS_TUNE_RESET;
    end else begin
      o_freq_select <= internal_frequency_select_q;
      o_freq_trim <= tune_q;
    end
  end
endmodule
`default_nettype wire

// file: test/cws_config_core_props.sv
// assertions on the clock source block ports
`timescale 1ns/1ps
`default_nettype none
module cws_config_core_props
  import cws_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // reset
  input wire logic i_master_clear_n, // master clear
  input wire cws_mode_t o_clock_source, // mode
  input wire cws_pins_t o_pins, // pin roles
  input wire logic o_secondary_pin_oe, // clock out drive
  input wire logic o_internal_osc_run, // internal run
  input wire logic o_rc_osc_run, // rc run
  input wire logic o_hold_reset, // reset hold
  input wire logic o_master_clear_pin_en // pin is master clear
);
  logic [2:0] m;
  // mode as a plain code
  assign m = o_clock_source;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_held;
    $past(i_reset_n, 3) && $past(i_reset_n, 2) && $past(i_reset_n) |-> $stable(o_clock_source);
  endproperty
  a_held: assert property (p_held) else $error("mode moved while running");
  property p_rc_out;
    m == 3'h7 |-> o_secondary_pin_oe && o_pins.secondary_clk_out && o_pins.primary_clock_in;
  endproperty
  a_rc_out: assert property (p_rc_out) else $error("rc clock out roles wrong");
  property p_rc_io;
    m == 3'h6 |-> !o_secondary_pin_oe && o_pins.secondary_gpio && o_pins.primary_clock_in;
  endproperty
  a_rc_io: assert property (p_rc_io) else $error("rc io roles wrong");
  property p_int_out;
    m == 3'h5 |-> o_secondary_pin_oe && o_pins.secondary_clk_out && o_pins.primary_gpio;
  endproperty
  a_int_out: assert property (p_int_out) else $error("internal clock out roles wrong");
  property p_int_io;
    m == 3'h4 |-> !o_secondary_pin_oe && o_pins.secondary_gpio && o_pins.primary_gpio;
  endproperty
  a_int_io: assert property (p_int_io) else $error("internal io roles wrong");
  property p_ext;
    m == 3'h3 |-> o_pins.primary_clock_in && o_pins.secondary_gpio && !o_secondary_pin_oe;
  endproperty
  a_ext: assert property (p_ext) else $error("external clock roles wrong");
  property p_xtal;
    m < 3'h3 |-> o_pins.resonator && !o_secondary_pin_oe;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal roles wrong");
  property p_no_ost;
    m == 3'h3 |-> ##[0:4] !o_hold_reset;
  endproperty
  a_no_ost: assert property (p_no_ost) else $error("external clock held in reset");
  property p_master_clear_input;
    !i_master_clear_n && o_master_clear_pin_en && m > 3'h3
      |-> ##[1:3] !(o_internal_osc_run || o_rc_osc_run);
  endproperty
  a_master_clear_input: assert property (p_master_clear_input) else $error("oscillator runs under master clear");
  // main scenarios reached
  cover property (m == 3'h7 && o_secondary_pin_oe);
  cover property (o_hold_reset ##1 !o_hold_reset);
  cover property (!i_master_clear_n && m > 3'h3);
endmodule
bind cws_config_core cws_config_core_props i_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_master_clear_n(i_master_clear_n),
  .o_clock_source(o_clock_source), .o_pins(o_pins), .o_secondary_pin_oe(o_secondary_pin_oe),
  .o_internal_osc_run(o_internal_osc_run), .o_rc_osc_run(o_rc_osc_run),
  .o_hold_reset(o_hold_reset), .o_master_clear_pin_en(o_master_clear_pin_en)
);
`default_nettype wire

// file: test/cws_osc_model.sv
// oscillator sources seen by the clock source block
`timescale 1ns/1ps
`default_nettype none
module cws_osc_model (
  input wire logic i_clk, // system clock
  input wire logic i_rc_run, // rc enable from block
  input wire logic i_int_run, // internal enable from block
  output var logic o_rc, // rc network level
  output var logic o_int, // internal oscillator level
  output var logic o_xtal // crystal on primary pin
);
  // start quiet, no unknown levels
  initial begin
    o_rc = 1'h0;
    o_int = 1'h0;
    o_xtal = 1'h0;
  end
  always @(posedge i_clk) begin
    o_rc <= i_rc_run ? ~o_rc : 1'h0;
    o_int <= i_int_run ? ~o_int : 1'h0;
  end
  always @(posedge i_clk) o_xtal <= ~o_xtal;
endmodule
`default_nettype wire

// file: test/testbench.sv
// testbench for the configuration word clock source block
`timescale 1ns/1ps
`default_nettype none
`include "cws_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench
  import cws_pkg::*;
;
  localparam logic [15:0] W1 = 16'(`CWS_WORD_ONE_IDX * 4);
  localparam logic [15:0] W2 = 16'(`CWS_WORD_TWO_IDX * 4);
  localparam logic [4:0] PT [8] = '{5'h01, 5'h01, 5'h01, 5'h0C, 5'h14, 5'h12, 5'h0C, 5'h0A};
  logic clk = 1'h0, rst_n = 1'h0, nv_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic prog = 1'h0, mc_n = 1'h1, ers = 1'h0, rcp = 1'h0, sop = 1'h0;
  logic [15:0] pa = 16'h0;
  logic [31:0] pwd = 32'h0, prd, rdata;
  logic perr, rdy, serr, oe, so, irun, rrun, hold, power_up_timer, erase, rc, io, xt;
  logic [1:0] bor;
  cws_mode_t src;
  cws_pins_t pins;
  int check_count = 0, miscompares = 0, cyc = 0, n, na = 0, nb = 0, a0, b0;
  cws_config_core i_cws_config_core (
    .i_clk(clk), .i_reset_n(rst_n), .i_nv_init_n(nv_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(rdata), .o_pready(rdy),
    .o_pslverr(serr), .i_program_mode(prog), .i_master_clear_n(mc_n), .i_wake(1'h0),
    .i_primary_osc_in(xt), .i_rc_osc(rc), .i_int_osc(io), .i_int_lock(1'h0),
    .i_int_stable(1'h0), .o_clock_source(src), .o_pins(pins), .o_secondary_pin_out(so),
    .o_secondary_pin_oe(oe), .o_internal_osc_run(irun), .o_rc_osc_run(rrun),
    .o_hold_reset(hold), .o_power_up_timer_en(power_up_timer), .o_brown_out_en(bor),
    .o_watchdog_en(), .o_master_clear_pin_en(), .o_erase_strobe(erase),
    .o_freq_select(), .o_freq_trim()
  );
  cws_osc_model i_cws_osc_model (
    .i_clk(clk), .i_rc_run(rrun), .i_int_run(irun), .o_rc(rc), .o_int(io), .o_xtal(xt)
  );
  // clock, edge counters and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    rcp <= rc;
    sop <= so;
    if (rc && !rcp) na++;
    if (so && !sop) nb++;
    if (erase === 1'h1) ers <= 1'h1;
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    prd = rdata;
    perr = serr;
    psel <= 1'h0;
    pen <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic reboot();
    rst_n <= 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
  endtask
  // register access, then every selection code
  initial begin
    reboot();
    nv_n <= 1'h1;
    apb(1'h1, W1, 32'h0);
    prog <= 1'h1;
    apb(1'h0, W1, 32'h0);
    `CHK("word1", `CWS_WORD_ONE_ERASED, prd[15:0])
    apb(1'h1, W2, 32'h3FCF);
    apb(1'h0, W2, 32'h0);
    `CHK("word2", 16'h3FCF, prd[15:0])
    apb(1'h0, `CWS_OSC_TUNING_ADDR, 32'h0);
    `CHK("tune", 6'h00, prd[5:0])
    apb(1'h0, 16'h00FC, 32'h0);
    `CHK("unmapped", 1'h1, perr)
    apb(1'h1, W1, 32'h3FBF);
    `CHK("erase_on", 1'h0, ers)
    apb(1'h1, W1, 32'h3FFF);
    `CHK("erase_off", 1'h1, ers)
    reboot();
    `CHK("bor", 2'h3, bor)
    `CHK("power_up_timer_off", 1'h0, power_up_timer)
    apb(1'h1, W1, 32'h3FEF);
    reboot();
    `CHK("power_up_timer_on", 1'h1, power_up_timer)
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, W1, 32'h3FF8 | c);
      reboot();
      `CHK("mode", cws_mode_t'(c), src)
      `CHK("pins", PT[c], c < 3 ? 5'(pins.resonator) : 5'(pins))
      `CHK("clk_oe", c == 7 || c == 5, oe)
      if (c < 3) begin
        n = 0;
        `CHK("ost_hold", 1'h1, hold)
        while (hold === 1'h1) begin
          @(posedge clk);
          n++;
        end
        `CHK("ost_len", 1'h1, n inside {[2030:2070]})
      end
      if (c == 3) `CHK("no_ost", 1'h0, hold)
      if (c == 7) begin
        a0 = na;
        b0 = nb;
        repeat (80) @(posedge clk);
        `CHK("div4", 1'h1, ((na - a0) / 4 - (nb - b0)) inside {[-1:1]})
      end
      if (c > 3) begin
        mc_n <= 1'h0;
        repeat (4) @(posedge clk);
        `CHK("osc_stop", 1'h0, irun | rrun)
        mc_n <= 1'h1;
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
